// file: logic/drive_monitor_status_bank.sv
/*
  Read-only monitor register bank of a motor drive, holding registers
  0x0020 to 0x002C, served to the serial link's frame engine.
  Assumes the frame engine (same clock) gives one-cycle read and write
  strobes with a register number, and that drive conditions arrive as
  same-clock levels; only the input terminals come straight from pins.
*/
// Behaviour
// - Every monitor register is read only and a write never changes what is read.
// - Drive status bits 0 to 5 give run, reverse, ready, fault, setting error and relay contact.
// - Drive status bits 6 and 7 give the optocoupler outputs, 14 and 15 the link sources, 8 to 13 zero.
// - First fault word bits 0 to 3 give overcurrent or ground, bus overvoltage, drive overload, overheat.
// - First fault word bit 4 brake resistor, bit 5 zero, bit 6 PID feedback, bit 7 external, bit 8 hardware.
// - First fault word bit 9 motor overload or torque faults, bit 10 encoder, overspeed or deviation.
// - First fault word bits 11 to 15 give bus undervoltage, any undervoltage, phase loss, comm loss, keypad.
// - Registers 0x0023 to 0x0028 return the live measurements, current at 10 counts per ampere.
// - Output voltage reads in 0.1 V counts unless the unit select asks for whole volts.
// - Second fault word bits 0 to 4 give short, ground, input phase loss, output phase loss, resistor heat.
// - Alarm word bits 2 to 5 give forward-reverse clash, output blocked, overtorque, heatsink heat.
// - Alarm word bits 6, 7, 9, 10, 11 give bus over and under voltage, comm, option error, undertorque.
// - Alarm word bit 12 prealarm, bit 13 PID feedback alarm, bit 15 waiting for the link.
// - Second status word gives run in bit 0, ready in bit 6, fault in bit 14, link timeout in bit 15.
`timescale 1ns/1ps
module drive_monitor_status_bank
  import drive_monitor_pkg::*;
(
  input  wire logic                           i_clk,                   // 100 MHz clock
  input  wire logic                           i_rstn,                  // Async reset, active low
  // Register access from the frame engine
  input  wire logic                           i_rd_req,                // Read strobe, one cycle
  input  wire logic                           i_wr_req,                // Write strobe, one cycle
  input  wire drive_monitor_pkg::addr_t       i_addr,                  // Register number
  output logic                                o_rd_valid,              // Read answer strobe
  output drive_monitor_pkg::word_t            o_rd_data,               // Read data
  output logic                                o_rd_err,                // Read outside the range
  output logic                                o_wr_refused,            // Write to a read-only register
  // Drive state
  input  wire logic                           i_running,               // Motor running
  input  wire logic                           i_reverse,               // Rotating in reverse
  input  wire logic                           i_ready,                 // Drive ready
  input  wire logic                           i_fault_present,         // Any fault
  input  wire logic                           i_setting_error,         // Data setting error
  input  wire logic                           i_relay_contact_output,  // Relay contact state
  input  wire logic                           i_optocoupler_output_one,// Opto output 1
  input  wire logic                           i_optocoupler_output_two,// Opto output 2
  input  wire logic                           i_link_reference_source, // Reference from link
  input  wire logic                           i_link_run_control_source, // Run control from link
  input  wire logic                           i_link_timeout,          // Link timeout
  // Fault conditions
  input  wire logic                           i_overcurrent_fault,     // Overcurrent
  input  wire logic                           i_ground_fault,          // Ground fault
  input  wire logic                           i_bus_overvoltage,       // Bus overvoltage
  input  wire logic                           i_drive_overload,        // Drive overload
  input  wire logic                           i_overheat_fault_one,    // Overheat fault
  input  wire logic                           i_overheat_prealarm,     // Overheat prealarm
  input  wire logic                           i_brake_resistor_overheat, // Brake resistor heat
  input  wire logic                           i_brake_transistor_fault,// Brake transistor
  input  wire logic                           i_pid_feedback_low,      // PID feedback low
  input  wire logic                           i_pid_feedback_high,     // PID feedback high
  input  wire logic                           i_external_fault_link,   // External fault from link
  input  wire logic [DIN_N-1:0]               i_external_fault_inputs, // External faults at inputs
  input  wire logic                           i_hardware_fault,        // Hardware fault
  input  wire logic                           i_option_hardware_fault, // Option hardware fault
  input  wire logic                           i_motor_overload,        // Motor overload
  input  wire logic                           i_overtorque_one,        // Overtorque 1
  input  wire logic                           i_overtorque_two,        // Overtorque 2
  input  wire logic                           i_undertorque_one,       // Undertorque 1
  input  wire logic                           i_undertorque_two,       // Undertorque 2
  input  wire logic                           i_encoder_disconnect,    // Encoder lost
  input  wire logic                           i_overspeed_fault,       // Overspeed
  input  wire logic                           i_speed_deviation,       // Speed deviation
  input  wire logic                           i_bus_undervoltage,      // Bus undervoltage
  input  wire logic                           i_control_supply_fault,  // Control supply
  input  wire logic                           i_inrush_circuit_fault,  // Inrush circuit
  input  wire logic                           i_input_phase_loss,      // Input phase loss
  input  wire logic                           i_output_phase_loss,     // Output phase loss
  input  wire logic                           i_comm_loss,             // Communication loss
  input  wire logic                           i_keypad_disconnected,   // Keypad gone
  input  wire logic                           i_load_short_circuit,    // Load short
  // Alarm conditions
  input  wire logic                           i_fwd_rev_conflict,      // Both directions commanded
  input  wire logic                           i_output_blocked,        // Output blocked
  input  wire logic                           i_heatsink_overheat,     // Heatsink alarm
  input  wire logic                           i_comm_error,            // Communication error
  input  wire logic                           i_option_error,          // Option error
  input  wire logic                           i_waiting_for_link,      // Waiting for link
  // Link transfer state
  input  wire logic                           i_link_writing,          // Writing data
  input  wire logic                           i_link_limit_error,      // Limit error
  input  wire logic                           i_link_integrity_error,  // Integrity error
  input  wire logic                           i_link_nvm_write,        // Storing to memory
  // Measurements and configuration
  input  wire drive_monitor_pkg::word_t       i_freq_reference,        // Frequency reference
  input  wire drive_monitor_pkg::word_t       i_output_freq,           // Output frequency
  input  wire drive_monitor_pkg::word_t       i_output_volt_tenths,    // Voltage, 0.1 V counts
  input  wire drive_monitor_pkg::word_t       i_output_current,        // Current, 0.1 A counts
  input  wire drive_monitor_pkg::word_t       i_output_power,          // Output power
  input  wire drive_monitor_pkg::word_t       i_torque_reference,      // Torque reference
  input  wire logic                           i_voltage_unit_select,   // 1: whole volts
  input  wire logic [DIN_N-1:0]               i_input_terminal_pins    // Digital input pins
);
  word_t             status_w;
  word_t             fault1_w;
  word_t             link_w;
  word_t             fault2_w;
  word_t             alarm_w;
  word_t             inputs_w;
  word_t             status2_w;
  word_t             volt_w;
  word_t             mux_w;
  logic [DIN_N-1:0]  input_closed;
  addr_t             rd_addr_r;

  // Range decode, shared by the read answer and the write refusal
  function automatic logic in_monitor_range(input addr_t a);
    in_monitor_range = (a >= ADDR_FIRST) && (a <= ADDR_LAST);
  endfunction

  // Terminal pins come from outside and must be filtered
  pin_sync #(
    .W       (DIN_N)
  ) u_input_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_input_terminal_pins),
    .o_level (input_closed)
  );

  volt_unit_scale u_volt_scale (
    .i_whole_volts (i_voltage_unit_select),
    .i_tenths      (i_output_volt_tenths),
    .o_value       (volt_w)
  );

  // Status words; anything not named stays zero
  always_comb begin
    status_w  = '0;
    status2_w = '0;
    status_w[ST_RUN]      = i_running;
    status_w[ST_REV]      = i_reverse;
    status_w[ST_READY]    = i_ready;
    status_w[ST_FAULT]    = i_fault_present;
    status_w[ST_SET_ERR]  = i_setting_error;
    status_w[ST_RELAY]    = i_relay_contact_output;
    status_w[ST_OPTO1]    = i_optocoupler_output_one;
    status_w[ST_OPTO2]    = i_optocoupler_output_two;
    status_w[ST_LINK_REF] = i_link_reference_source;
    status_w[ST_LINK_RUN] = i_link_run_control_source;
    status2_w[S2_RUN]     = i_running;
    status2_w[S2_READY]   = i_ready;
    status2_w[S2_FAULT]   = i_fault_present;
    status2_w[S2_TIMEOUT] = i_link_timeout;
  end

  // First fault word; several causes fold into one flag
  always_comb begin
    fault1_w = '0;
    fault1_w[F1_OC]     = i_overcurrent_fault | i_ground_fault;
    fault1_w[F1_OV]     = i_bus_overvoltage;
    fault1_w[F1_OL2]    = i_drive_overload;
    fault1_w[F1_OH]     = i_overheat_fault_one | i_overheat_prealarm;
    fault1_w[F1_BRAKE]  = i_brake_resistor_overheat | i_brake_transistor_fault;
    fault1_w[F1_PID]    = i_pid_feedback_low | i_pid_feedback_high;
    fault1_w[F1_EXT]    = i_external_fault_link | (|i_external_fault_inputs);
    fault1_w[F1_HW]     = i_hardware_fault | i_option_hardware_fault;
    fault1_w[F1_MOTOR]  = i_motor_overload | i_overtorque_one | i_overtorque_two
                        | i_undertorque_one | i_undertorque_two;
    fault1_w[F1_ENC]    = i_encoder_disconnect | i_overspeed_fault | i_speed_deviation;
    fault1_w[F1_UV_BUS] = i_bus_undervoltage;
    fault1_w[F1_UV_ANY] = i_bus_undervoltage | i_control_supply_fault | i_inrush_circuit_fault;
    fault1_w[F1_PHASE]  = i_input_phase_loss | i_output_phase_loss;
    fault1_w[F1_COMM]   = i_comm_loss;
    fault1_w[F1_KEYPAD] = i_keypad_disconnected;
  end

  // Link transfer, second fault and input words
  always_comb begin
    link_w   = '0;
    fault2_w = '0;
    inputs_w = '0;
    link_w[LK_WRITING]   = i_link_writing;
    link_w[LK_LIMIT]     = i_link_limit_error;
    link_w[LK_INTEGRITY] = i_link_integrity_error;
    link_w[LK_NVM]       = i_link_nvm_write;
    fault2_w[F2_SC]      = i_load_short_circuit;
    fault2_w[F2_GF]      = i_ground_fault;
    fault2_w[F2_BUSV]    = i_input_phase_loss;
    fault2_w[F2_OPL]     = i_output_phase_loss;
    fault2_w[F2_RH]      = i_brake_resistor_overheat;
    inputs_w[DIN_N-1:0]  = input_closed;
  end

  // Alarm word; bus voltage alarms share the fault sources
  always_comb begin
    alarm_w = '0;
    alarm_w[AL_FWDREV]   = i_fwd_rev_conflict;
    alarm_w[AL_BLOCK]    = i_output_blocked;
    alarm_w[AL_OT]       = i_overtorque_one;
    alarm_w[AL_HEATSINK] = i_heatsink_overheat;
    alarm_w[AL_OV]       = i_bus_overvoltage;
    alarm_w[AL_UV]       = i_bus_undervoltage;
    alarm_w[AL_COMM]     = i_comm_error;
    alarm_w[AL_OPTION]   = i_option_error;
    alarm_w[AL_UT]       = i_undertorque_one;
    alarm_w[AL_PREHEAT]  = i_overheat_prealarm;
    alarm_w[AL_PID]      = i_pid_feedback_low | i_pid_feedback_high;
    alarm_w[AL_CALL]     = i_waiting_for_link;
  end

  always_comb begin
    case (i_addr)
      ADDR_DRIVE_STATUS:   mux_w = status_w;
      ADDR_FAULT_FIRST:    mux_w = fault1_w;
      ADDR_LINK_STATUS:    mux_w = link_w;
      ADDR_FREQ_REF:       mux_w = i_freq_reference;
      ADDR_OUT_FREQ:       mux_w = i_output_freq;
      ADDR_OUT_VOLT:       mux_w = volt_w;
      ADDR_OUT_CURRENT:    mux_w = i_output_current;
      ADDR_OUT_POWER:      mux_w = i_output_power;
      ADDR_TORQUE_REF:     mux_w = i_torque_reference;
      ADDR_FAULT_SECOND:   mux_w = fault2_w;
      ADDR_ALARM:          mux_w = alarm_w;
      ADDR_INPUT_TERMINAL: mux_w = inputs_w;
      ADDR_STATUS_TWO:     mux_w = status2_w;
      default:             mux_w = '0;
    endcase
  end

  // Answer strobe follows every read by one cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rd_err   <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_req;
      o_rd_err   <= i_rd_req && !in_monitor_range(i_addr);
    end
  end

  // Sample at the read
  // Data is taken in the strobe cycle, so flags are not latched history
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= '0;
      rd_addr_r <= '0;
    end else if (i_rd_req) begin
      o_rd_data <= mux_w;
      rd_addr_r <= i_addr;
    end
  end

  // Writes inside the monitor range are refused
  // Nothing in the bank has a write path; the strobe only reports refusal
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr_refused <= 1'b0;
    end else begin
      o_wr_refused <= i_wr_req && in_monitor_range(i_addr);
    end
  end

  // Checks on the answer path
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_read(addr_t a);
    i_rd_req && !i_wr_req && (i_addr == a);
  endsequence

  property p_rd_valid;
    i_rd_req |=> o_rd_valid ##1 (!o_rd_valid || $past(i_rd_req));
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer strobe wrong");

  property p_wr_refused;
    i_wr_req && !i_rd_req && (i_addr == ADDR_OUT_CURRENT) |=> o_wr_refused && !o_rd_valid;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write not refused");

  // A read a few cycles after a write must still show the live source, not the written value
  property p_wr_no_effect;
    (i_wr_req && (i_addr == ADDR_OUT_CURRENT)) ##[1:4] s_read(ADDR_OUT_CURRENT)
      |=> o_rd_data == $past(i_output_current);
  endproperty
  a_wr_no_effect: assert property (p_wr_no_effect) else $error("write altered read data");

  property p_status_run;
    s_read(ADDR_DRIVE_STATUS) |=> o_rd_data[ST_RUN] == $past(i_running)
      && o_rd_data[ST_OPTO2] == $past(i_optocoupler_output_two) && o_rd_data[13:8] == '0;
  endproperty
  a_status_run: assert property (p_status_run) else $error("status word wrong");

  property p_fault1;
    s_read(ADDR_FAULT_FIRST) |=> o_rd_data[F1_OC] == $past(i_overcurrent_fault | i_ground_fault)
      && o_rd_data[5] == 1'b0 && o_rd_data[F1_KEYPAD] == $past(i_keypad_disconnected);
  endproperty
  a_fault1: assert property (p_fault1) else $error("first fault word wrong");

  property p_current;
    s_read(ADDR_OUT_CURRENT) |=> o_rd_data == $past(i_output_current);
  endproperty
  a_current: assert property (p_current) else $error("current register wrong");

  property p_volt_unit;
    s_read(ADDR_OUT_VOLT) ##0 i_voltage_unit_select |=> o_rd_data == $past(i_output_volt_tenths) / 10;
  endproperty
  a_volt_unit: assert property (p_volt_unit) else $error("voltage unit wrong");

  property p_inputs_upper;
    s_read(ADDR_INPUT_TERMINAL) |=> o_rd_data[WORD_W-1:DIN_N] == '0;
  endproperty
  a_inputs_upper: assert property (p_inputs_upper) else $error("terminal upper bits set");

  property p_status2;
    s_read(ADDR_STATUS_TWO) |=> o_rd_data[S2_FAULT] == $past(i_fault_present)
      && o_rd_data[S2_TIMEOUT] == $past(i_link_timeout);
  endproperty
  a_status2: assert property (p_status2) else $error("second status word wrong");

  property p_fault2;
    s_read(ADDR_FAULT_SECOND) |=> o_rd_data[F2_BUSV] == $past(i_input_phase_loss)
      && o_rd_data[WORD_W-1:F2_RH+1] == '0;
  endproperty
  a_fault2: assert property (p_fault2) else $error("second fault word wrong");

  property p_alarm;
    s_read(ADDR_ALARM) |=> o_rd_data[AL_CALL] == $past(i_waiting_for_link)
      && o_rd_data[AL_UV] == $past(i_bus_undervoltage) && o_rd_data[AL_PID+1] == 1'b0;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm word wrong");

  property p_unmapped;
    o_rd_valid && !in_monitor_range(rd_addr_r) |-> o_rd_err && o_rd_data == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");
endmodule

// file: logic/drive_monitor_pkg.sv
/*
  Shared constants of the drive monitor register bank: register numbers,
  bit positions inside each monitor word and the voltage scaling figures.
  Assumes a single 100 MHz clock domain and 16-bit holding registers.
*/
package drive_monitor_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int DIN_N  = 7;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;

  // Holding register numbers of the monitor range
  localparam addr_t ADDR_DRIVE_STATUS   = 16'h0020;
  localparam addr_t ADDR_FAULT_FIRST    = 16'h0021;
  localparam addr_t ADDR_LINK_STATUS    = 16'h0022;
  localparam addr_t ADDR_FREQ_REF       = 16'h0023;
  localparam addr_t ADDR_OUT_FREQ       = 16'h0024;
  localparam addr_t ADDR_OUT_VOLT       = 16'h0025;
  localparam addr_t ADDR_OUT_CURRENT    = 16'h0026;
  localparam addr_t ADDR_OUT_POWER      = 16'h0027;
  localparam addr_t ADDR_TORQUE_REF     = 16'h0028;
  localparam addr_t ADDR_FAULT_SECOND   = 16'h0029;
  localparam addr_t ADDR_ALARM          = 16'h002a;
  localparam addr_t ADDR_INPUT_TERMINAL = 16'h002b;
  localparam addr_t ADDR_STATUS_TWO     = 16'h002c;
  localparam addr_t ADDR_FIRST          = ADDR_DRIVE_STATUS;
  localparam addr_t ADDR_LAST           = ADDR_STATUS_TWO;

  // Drive status word
  localparam int ST_RUN = 0, ST_REV = 1, ST_READY = 2, ST_FAULT = 3, ST_SET_ERR = 4;
  localparam int ST_RELAY = 5, ST_OPTO1 = 6, ST_OPTO2 = 7, ST_LINK_REF = 14, ST_LINK_RUN = 15;
  // First fault word
  localparam int F1_OC = 0, F1_OV = 1, F1_OL2 = 2, F1_OH = 3, F1_BRAKE = 4, F1_PID = 6;
  localparam int F1_EXT = 7, F1_HW = 8, F1_MOTOR = 9, F1_ENC = 10, F1_UV_BUS = 11;
  localparam int F1_UV_ANY = 12, F1_PHASE = 13, F1_COMM = 14, F1_KEYPAD = 15;
  // Link transfer status word
  localparam int LK_WRITING = 0, LK_LIMIT = 3, LK_INTEGRITY = 4, LK_NVM = 5;
  // Second fault word
  localparam int F2_SC = 0, F2_GF = 1, F2_BUSV = 2, F2_OPL = 3, F2_RH = 4;
  // Alarm word
  localparam int AL_FWDREV = 2, AL_BLOCK = 3, AL_OT = 4, AL_HEATSINK = 5, AL_OV = 6;
  localparam int AL_UV = 7, AL_COMM = 9, AL_OPTION = 10, AL_UT = 11, AL_PREHEAT = 12;
  localparam int AL_PID = 13, AL_CALL = 15;
  // Second status word
  localparam int S2_RUN = 0, S2_READY = 6, S2_FAULT = 14, S2_TIMEOUT = 15;

  // Tenths of a volt to whole volts: floor(x*52429 / 2^19) equals floor(x/10) for 16 bits
  localparam logic [16:0] DIV10_MUL   = 17'h0cccd;
  localparam int          DIV10_SHIFT = 19;
endpackage

// file: logic/pin_sync.sv
/*
  Three-stage synchroniser for a group of slow pins. A change is taken
  once the second and third stages agree. Assumes pins are quasi-static.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // System clock
  input  wire logic         i_rstn,  // Asynchronous reset, active low
  input  wire logic [W-1:0] i_pin,   // Raw pin levels
  output logic      [W-1:0] o_level  // Filtered level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Stage chain; the first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
    end else begin
      meta_r <= i_pin;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
    end
  end

  // Per bit, accept only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          o_level[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          o_level[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule

// file: logic/volt_unit_scale.sv
/*
  Output voltage unit selection: passes tenths of a volt, or converts
  them to whole volts. Pure combinational; the caller registers it.
*/
`timescale 1ns/1ps
module volt_unit_scale
  import drive_monitor_pkg::*;
(
  input  wire logic  i_whole_volts,  // 1: report whole volts
  input  wire word_t i_tenths,       // Voltage in 0.1 V counts
  output word_t      o_value         // Value as reported
);
  logic [33:0] prod;

  // Multiply-and-shift avoids a real divider
  always_comb begin
    prod    = {17'h00000, i_tenths} * {17'h00000, DIV10_MUL};
    o_value = i_whole_volts ? prod[DIV10_SHIFT +: WORD_W] : i_tenths;
  end
endmodule

// file: dv/link_master.sv
/* Link master model: one register read or write at a time.
   Assumes the bank answers one cycle after the taking edge. */
`timescale 1ns/1ps
module link_master (
  input  wire logic                     i_clk,        // Clock
  input  wire logic                     i_rd_valid,   // Read answer strobe
  input  wire drive_monitor_pkg::word_t i_rd_data,    // Read data
  input  wire logic                     i_rd_err,     // Range error
  input  wire logic                     i_wr_refused, // Write refused
  output logic                          o_rd_req,     // Read strobe
  output logic                          o_wr_req,     // Write strobe
  output drive_monitor_pkg::addr_t      o_addr        // Register number
);
  import drive_monitor_pkg::*;
  // Idle at time zero
  initial begin
    o_rd_req = 1'b0;
    o_wr_req = 1'b0;
    o_addr   = 16'h0000;
  end
  // Address is inverted once released so nothing can lean on a stale number
  task automatic access(input addr_t a, input logic wr, output word_t d, output logic v, output logic e);
    @(posedge i_clk);
    o_rd_req <= !wr;
    o_wr_req <= wr;
    o_addr   <= a;
    @(posedge i_clk);
    o_rd_req <= 1'b0;
    o_wr_req <= 1'b0;
    o_addr   <= ~a;
    @(posedge i_clk);
    d = i_rd_data;
    v = wr ? i_wr_refused : i_rd_valid;
    e = i_rd_err;
  endtask
endmodule

// file: dv/drive_monitor_status_bank_tb_top.sv
/* Self-checking bench of the monitor bank against a behavioural word model.
   Assumes link_master as the only register client. */
`timescale 1ns/1ps
module drive_monitor_status_bank_tb_top;
  import drive_monitor_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [50:0] f = 51'h0;      // Drive conditions, one bit per input
  logic [6:0]  ext = 7'h00;
  logic [6:0]  pins = 7'h00;
  word_t       m[6] = '{default: 16'h0000};
  logic        rd, wr, vld, err, refd, v, e;
  word_t       rdata, d, x;
  addr_t       addr;
  int          n_fail = 0;
  int          checks = 0;
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  drive_monitor_status_bank i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rd_req(rd), .i_wr_req(wr), .i_addr(addr), .o_rd_valid(vld),
    .o_rd_data(rdata), .o_rd_err(err), .o_wr_refused(refd), .i_running(f[0]), .i_reverse(f[1]),
    .i_ready(f[2]), .i_fault_present(f[3]), .i_setting_error(f[4]), .i_relay_contact_output(f[5]),
    .i_optocoupler_output_one(f[6]), .i_optocoupler_output_two(f[7]), .i_link_reference_source(f[8]),
    .i_link_run_control_source(f[9]), .i_link_timeout(f[10]), .i_overcurrent_fault(f[11]), .i_ground_fault(f[12]),
    .i_bus_overvoltage(f[13]), .i_drive_overload(f[14]), .i_overheat_fault_one(f[15]), .i_overheat_prealarm(f[16]),
    .i_brake_resistor_overheat(f[17]), .i_brake_transistor_fault(f[18]), .i_pid_feedback_low(f[19]),
    .i_pid_feedback_high(f[20]), .i_external_fault_link(f[21]), .i_external_fault_inputs(ext),
    .i_hardware_fault(f[22]), .i_option_hardware_fault(f[23]), .i_motor_overload(f[24]), .i_overtorque_one(f[25]),
    .i_overtorque_two(f[26]), .i_undertorque_one(f[27]), .i_undertorque_two(f[28]), .i_encoder_disconnect(f[29]),
    .i_overspeed_fault(f[30]), .i_speed_deviation(f[31]), .i_bus_undervoltage(f[32]),
    .i_control_supply_fault(f[33]), .i_inrush_circuit_fault(f[34]), .i_input_phase_loss(f[35]),
    .i_output_phase_loss(f[36]), .i_comm_loss(f[37]), .i_keypad_disconnected(f[38]), .i_load_short_circuit(f[39]),
    .i_fwd_rev_conflict(f[40]), .i_output_blocked(f[41]), .i_heatsink_overheat(f[42]), .i_comm_error(f[43]),
    .i_option_error(f[44]), .i_waiting_for_link(f[45]), .i_link_writing(f[46]), .i_link_limit_error(f[47]),
    .i_link_integrity_error(f[48]), .i_link_nvm_write(f[49]), .i_freq_reference(m[0]), .i_output_freq(m[1]),
    .i_output_volt_tenths(m[2]), .i_output_current(m[3]), .i_output_power(m[4]), .i_torque_reference(m[5]),
    .i_voltage_unit_select(f[50]), .i_input_terminal_pins(pins));
  link_master i_master (.i_clk(i_clk), .i_rd_valid(vld), .i_rd_data(rdata), .i_rd_err(err),
    .i_wr_refused(refd), .o_rd_req(rd), .o_wr_req(wr), .o_addr(addr));
  function automatic word_t model(input int a);
    case (a)
      32: return {f[9:8], 6'h00, f[7:0]};
      33: return {f[38], f[37], f[35]|f[36], |f[34:32], f[32], |f[31:29], |f[28:24], |f[23:22],
                  f[21]|(|ext), |f[20:19], 1'b0, |f[18:17], |f[16:15], f[14], f[13], |f[12:11]};
      34: return {10'h000, f[49:47], 2'h0, f[46]};
      35, 36, 38, 39, 40: return m[a-35];
      37: return f[50] ? word_t'(int'(m[2]) / 10) : m[2];
      41: return {11'h000, f[17], f[36], f[35], f[12], f[39]};
      42: return {f[45], 1'b0, |f[20:19], f[16], f[27], f[44], f[43], 1'b0, f[32], f[13], f[42], f[25], f[41:40], 2'h0};
      43: return {9'h000, pins};
      44: return {f[10], f[3], 7'h00, f[2], 5'h00, f[0]};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk_word(input word_t got, input word_t exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Random conditions; every address around the range is written, then read back
  initial begin
    void'($urandom(32'h1d36));
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (40) begin
      @(posedge i_clk);
      f <= 51'({$urandom, $urandom});
      ext <= ($urandom % 4 == 0) ? 7'($urandom) : 7'h00;
      pins <= 7'($urandom);
      foreach (m[k]) m[k] <= word_t'($urandom);
      repeat (8) @(posedge i_clk);
      for (int a = 31; a <= 45; a++) begin
        x = model(a);
        i_master.access(addr_t'(a), 1'b1, d, v, e);
        chk_flag(v, a > 31 && a < 45);
        i_master.access(addr_t'(a), 1'b0, d, v, e);
        chk_flag(v, 1'b1);
        chk_flag(e, a < 32 || a > 44);
        chk_word(d, x);
      end
    end
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
